/* scp_defines.svh */
// constants of the serial configuration port: offsets, fields, resets and timing
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SCP_OFF_CTRL 32'h0000_0000
`define SCP_OFF_FRAME_BITS 32'h0000_0004
`define SCP_OFF_STATUS 32'h0000_0008
`define SCP_OFF_LENGTH 32'h0000_000c
`define SCP_OFF_CLOCKS 32'h0000_0010

// ---------------------------------------------------------------
// control fields and reset values
// ---------------------------------------------------------------
`define SCP_CTRL_FAST 0
`define SCP_CTRL_USER_LOW 1
`define SCP_CTRL_USER_HIGH 2
`define SCP_CTRL_RESET 3'h2
`define SCP_FRAME_BITS_RESET 24'h00_0040

// ---------------------------------------------------------------
// bitstream codes and mode pin encodings
// ---------------------------------------------------------------
`define SCP_PREAMBLE 4'h2
`define SCP_MODE_SLAVE 2'h3
`define SCP_MODE_MASTER 2'h2
`define SCP_LEN_LAST 5'h17
`define SCP_FAST_AFTER_BITS 24'h00_0008

// ---------------------------------------------------------------
// timing: times in ns, cycle counts derived from the clock period
// ---------------------------------------------------------------
`define SCP_CLK_PERIOD_NS 4
`define SCP_SLOW_PERIOD_NS 1000
`define SCP_FAST_FACTOR 8
`define SCP_SLOW_HALF (`SCP_SLOW_PERIOD_NS / (2 * `SCP_CLK_PERIOD_NS))
`define SCP_FAST_HALF (`SCP_SLOW_HALF / `SCP_FAST_FACTOR)
`define SCP_INIT_CLEAR_NS 1000
`define SCP_INIT_CLEAR_CYC (`SCP_INIT_CLEAR_NS / `SCP_CLK_PERIOD_NS)

`endif

/* scp_pkg.sv */
// types shared by the serial configuration port
package scp_pkg;

   // ------------------------------------------------------------
   // configuration sequencer states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      SCP_IDLE = 6'h01,
      SCP_CLEAR = 6'h02,
      SCP_WAIT_INIT = 6'h04,
      SCP_LOAD = 6'h08,
      SCP_STARTUP = 6'h10,
      SCP_DONE = 6'h20
   } scp_state_t;

   // ------------------------------------------------------------
   // bitstream parse phases inside the load state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SCP_SEEK = 2'h0,
      SCP_LEN = 2'h1,
      SCP_FILL = 2'h2,
      SCP_DATA = 2'h3
   } scp_phase_t;

   // status word as software reads it
   typedef struct packed {
      logic [18:0] zero;
      logic done;
      logic loaded;
      logic mode_error;
      logic [1:0] mode;
      logic [1:0] phase;
      logic [5:0] state;
   } scp_status_t;

   // latched ahb address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } scp_ahb_req_t;

endpackage

/* scp_serial_config_port.sv */
// serial configuration port with ahb-lite register access
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "scp_defines.svh"

module scp_serial_config_port (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic mode_select_high,
   input wire logic mode_select_low,
   input wire logic program_n,
   input wire logic init_in,
   output logic init_out,
   output logic init_oe,
   input wire logic config_clock_in,
   output logic config_clock_out,
   output logic config_clock_oe,
   input wire logic din,
   output logic dout,
   output logic done,
   output logic high_during_config,
   output logic low_during_config
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   scp_pkg::scp_state_t state;
   scp_pkg::scp_phase_t phase;
   scp_pkg::scp_ahb_req_t req;
   scp_pkg::scp_status_t status;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic cc_last;
   logic [1:0] mode;
   logic mode_error;
   logic master;
   logic [2:0] ctrl;
   logic [23:0] frame_bits;
   logic [23:0] length;
   logic [23:0] clk_count;
   logic [23:0] own_count;
   logic [4:0] len_count;
   logic [3:0] shift;
   logic loaded;
   logic fast;
   logic fwd_bit;
   logic su_count;
   logic [7:0] div;
   logic [7:0] init_count;
   logic rise;
   logic fall;
   logic m_rise;
   logic m_fall;
   logic running;
   logic [7:0] half;
   logic [3:0] next_shift;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // order: clock, data, program, init, mode low; high pin handled apart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         cc_last <= 1'b0;
      end else begin
         sync1 <= {config_clock_in, din, program_n, init_in, mode_select_low};
         sync2 <= sync1;
         cc_last <= sync2[4];
      end
   end

   logic mh_s1;
   logic mh_s2;
   // mode high pin, separate so the pull-up default reads as one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mh_s1 <= 1'b1;
         mh_s2 <= 1'b1;
      end else begin
         mh_s1 <= mode_select_high;
         mh_s2 <= mh_s1;
      end
   end

   // ------------------------------------------------------------
   // configuration clock edges
   // ------------------------------------------------------------
   // slave edges come from the second sync stage, master edges from the divider
   assign running = (state == scp_pkg::SCP_LOAD) || (state == scp_pkg::SCP_STARTUP);
   assign half = fast ? 8'(`SCP_FAST_HALF) : 8'(`SCP_SLOW_HALF);
   assign m_rise = master && running && (div == 8'h00) && !config_clock_out;
   assign m_fall = master && running && (div == 8'h00) && config_clock_out;
   assign rise = master ? m_rise : (running && sync2[4] && !cc_last);
   assign fall = master ? m_fall : (running && !sync2[4] && cc_last);

   // internal oscillator divider for master mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= 8'h00;
         config_clock_out <= 1'b0;
         config_clock_oe <= 1'b0;
      end else begin
         config_clock_oe <= master && running;
         if (!(master && running)) begin
            div <= 8'h00;
            config_clock_out <= 1'b0;
         end else if (div == 8'h00) begin
            div <= half - 8'h01;
            config_clock_out <= !config_clock_out;
         end else begin
            div <= div - 8'h01;
         end
      end
   end

   // fast rate only a few bits into the first frame, never before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast <= 1'b0;
      end else if (!running) begin
         fast <= 1'b0;
      end else if (ctrl[`SCP_CTRL_FAST] && phase == scp_pkg::SCP_DATA
                   && own_count >= `SCP_FAST_AFTER_BITS) begin
         fast <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // configuration sequencer
   // ------------------------------------------------------------
   // program low aborts from any state and holds the block idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= scp_pkg::SCP_IDLE;
         init_count <= 8'h00;
         mode <= `SCP_MODE_SLAVE;
         mode_error <= 1'b0;
         master <= 1'b0;
         su_count <= 1'b0;
      end else if (!sync2[2]) begin
         state <= scp_pkg::SCP_IDLE;
         master <= 1'b0;
      end else begin
         case (state)
            scp_pkg::SCP_IDLE: begin
               init_count <= 8'(`SCP_INIT_CLEAR_CYC - 1);
               state <= scp_pkg::SCP_CLEAR;
            end
            scp_pkg::SCP_CLEAR: begin
               if (init_count == 8'h00) begin
                  state <= scp_pkg::SCP_WAIT_INIT;
               end else begin
                  init_count <= init_count - 8'h01;
               end
            end
            scp_pkg::SCP_WAIT_INIT: begin
               mode <= {mh_s2, sync2[0]};
               mode_error <= !mh_s2;
               if (sync2[1] && mh_s2) begin
                  master <= !sync2[0];
                  state <= scp_pkg::SCP_LOAD;
               end
            end
            scp_pkg::SCP_LOAD: begin
               su_count <= 1'b0;
               if (rise && phase >= scp_pkg::SCP_FILL && clk_count + 24'h1 == length) begin
                  state <= scp_pkg::SCP_STARTUP;
               end
            end
            scp_pkg::SCP_STARTUP: begin
               if (rise) begin
                  su_count <= 1'b1;
                  if (su_count) begin
                     state <= scp_pkg::SCP_DONE;
                  end
               end
            end
            scp_pkg::SCP_DONE: begin
               master <= 1'b0;
            end
            default: begin
               state <= scp_pkg::SCP_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // bitstream parser and forwarding path
   // ------------------------------------------------------------
   assign next_shift = {shift[2:0], sync2[3]};

   // bits taken on rising edges, header passed on, output held high while loading own frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= scp_pkg::SCP_SEEK;
         shift <= 4'hf;
         length <= 24'h00_0000;
         len_count <= 5'h00;
         clk_count <= 24'h00_0000;
         own_count <= 24'h00_0000;
         loaded <= 1'b0;
         fwd_bit <= 1'b1;
      end else if (state != scp_pkg::SCP_LOAD && state != scp_pkg::SCP_STARTUP) begin
         phase <= scp_pkg::SCP_SEEK;
         shift <= 4'hf;
         len_count <= 5'h00;
         clk_count <= 24'h00_0000;
         own_count <= 24'h00_0000;
         loaded <= 1'b0;
         fwd_bit <= 1'b1;
      end else if (rise) begin
         clk_count <= clk_count + 24'h1;
         shift <= next_shift;
         case (phase)
            scp_pkg::SCP_SEEK: begin
               fwd_bit <= sync2[3];
               if (next_shift == `SCP_PREAMBLE) begin
                  phase <= scp_pkg::SCP_LEN;
               end
            end
            scp_pkg::SCP_LEN: begin
               fwd_bit <= sync2[3];
               length <= {length[22:0], sync2[3]};
               len_count <= len_count + 5'h01;
               if (len_count == `SCP_LEN_LAST) begin
                  phase <= scp_pkg::SCP_FILL;
               end
            end
            scp_pkg::SCP_FILL: begin
               fwd_bit <= 1'b1;
               if (!sync2[3]) begin
                  phase <= scp_pkg::SCP_DATA;
                  own_count <= 24'h00_0001;
                  loaded <= (frame_bits == 24'h00_0001);
               end
            end
            scp_pkg::SCP_DATA: begin
               if (loaded) begin
                  fwd_bit <= sync2[3];
               end else begin
                  fwd_bit <= 1'b1;
                  own_count <= own_count + 24'h1;
                  loaded <= (own_count + 24'h1 >= frame_bits);
               end
            end
            default: begin
               phase <= scp_pkg::SCP_SEEK;
            end
         endcase
      end
   end

   // output changes on falling edges: half period in slave, 1.5 from prom in master
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout <= 1'b1;
      end else if (!running) begin
         dout <= 1'b1;
      end else if (fall) begin
         dout <= fwd_bit;
      end
   end

   // ------------------------------------------------------------
   // status pins
   // ------------------------------------------------------------
   // init only ever pulls low, in idle and during memory clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_out <= 1'b0;
         init_oe <= 1'b0;
         done <= 1'b0;
         high_during_config <= 1'b1;
         low_during_config <= 1'b0;
      end else begin
         init_out <= 1'b0;
         init_oe <= (state == scp_pkg::SCP_IDLE) || (state == scp_pkg::SCP_CLEAR);
         done <= (state == scp_pkg::SCP_DONE);
         if (state == scp_pkg::SCP_DONE) begin
            high_during_config <= ctrl[`SCP_CTRL_USER_HIGH];
            low_during_config <= ctrl[`SCP_CTRL_USER_LOW];
         end else begin
            high_during_config <= 1'b1;
            low_during_config <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // ahb-lite register slave, zero wait states
   // ------------------------------------------------------------
   always_comb begin
      status = '0;
      status.state = state;
      status.phase = phase;
      status.mode = mode;
      status.mode_error = mode_error;
      status.loaded = loaded;
      status.done = done;
   end

   // address phase latched and read data prepared for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req <= '0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         req.valid <= hsel && hready && htrans[1];
         req.write <= hwrite;
         req.addr <= haddr;
         if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == `SCP_OFF_CTRL) begin
               hrdata <= {29'h0, ctrl};
            end else if (haddr == `SCP_OFF_FRAME_BITS) begin
               hrdata <= {8'h00, frame_bits};
            end else if (haddr == `SCP_OFF_STATUS) begin
               hrdata <= status;
            end else if (haddr == `SCP_OFF_LENGTH) begin
               hrdata <= {8'h00, length};
            end else if (haddr == `SCP_OFF_CLOCKS) begin
               hrdata <= {8'h00, clk_count};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // writes land at the data phase edge; unmapped writes vanish
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `SCP_CTRL_RESET;
         frame_bits <= `SCP_FRAME_BITS_RESET;
      end else if (req.valid && req.write) begin
         if (req.addr == `SCP_OFF_CTRL) begin
            ctrl <= hwdata[2:0];
         end else if (req.addr == `SCP_OFF_FRAME_BITS) begin
            frame_bits <= hwdata[23:0];
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_prog_low;
      !sync2[2];
   endsequence

   // rises seen since start-up began; a counter keeps the release check short
   logic [1:0] su_rises;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         su_rises <= 2'h0;
      end else if (state != scp_pkg::SCP_STARTUP) begin
         su_rises <= 2'h0;
      end else if (rise && su_rises != 2'h3) begin
         su_rises <= su_rises + 2'h1;
      end
   end

   sequence s_second_rise;
      (state == scp_pkg::SCP_STARTUP) && rise && (su_rises == 2'h1);
   endsequence

   a_prog_holds_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      s_prog_low |=> state == scp_pkg::SCP_IDLE)
      else $error("program low did not hold idle");

   a_init_open_drain: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == scp_pkg::SCP_CLEAR) |=> init_oe && !init_out)
      else $error("init not pulled low in clear");

   a_start_needs_init: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == scp_pkg::SCP_WAIT_INIT && !sync2[1]) |=> state != scp_pkg::SCP_LOAD)
      else $error("load began with init low");

   a_express_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == scp_pkg::SCP_WAIT_INIT && !mh_s2) |=> state != scp_pkg::SCP_LOAD)
      else $error("express mode started serial load");

   a_slow_first: assert property (@(posedge hclk) disable iff (!hresetn)
      (fast && running) |-> phase == scp_pkg::SCP_DATA)
      else $error("fast rate before first frame");

   a_config_levels: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(state) == scp_pkg::SCP_LOAD |-> high_during_config && !low_during_config)
      else $error("config level outputs wrong");

   a_startup_release: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_second_rise ##0 sync2[2]) |=> state == scp_pkg::SCP_DONE)
      else $error("release not two clocks after end");

   a_no_early_release: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == scp_pkg::SCP_STARTUP && su_rises == 2'h0) |=> state != scp_pkg::SCP_DONE)
      else $error("released before second clock");

   a_hold_high: assert property (@(posedge hclk) disable iff (!hresetn)
      (fall && phase == scp_pkg::SCP_DATA && !loaded) |=> dout)
      else $error("output not high while loading");

   a_slave_clock_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
      (!master && !$past(master)) |-> !config_clock_oe)
      else $error("slave drove clock pin");

   a_done_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == scp_pkg::SCP_DONE) |=> done || !sync2[2])
      else $error("done flag missing");

endmodule
`default_nettype wire

/* scp_prom_model.sv */
// behavioural serial prom and upstream master for the configuration port
`timescale 1ns/1ns
`default_nettype none
module scp_prom_model (
   input wire logic master_mode,
   input wire logic run,
   input wire logic [63:0] stream,
   input wire logic link_clk_pin,
   input wire logic dout,
   output logic link_clk_drive,
   output logic din,
   output int rises,
   output logic [127:0] dout_log
);
   // bits past the image read as start-up ones
   function automatic logic bit_at(input int i);
      return (i < 64) ? stream[63 - i] : 1'b1;
   endfunction

   initial begin
      link_clk_drive = 1'b0;
      din = 1'b1;
      rises = 0;
      dout_log = '0;
   end

   // slave clock of 64 ns, low and still outside a stream; first rise comes late
   // so the port is already loading, and every edge falls on a falling hclk edge
   always @(posedge run) begin
      if (!master_mode) begin
         #98;
         while (run) begin
            link_clk_drive = ~link_clk_drive;
            #32;
         end
         link_clk_drive = 1'b0;
      end
   end

   // a released data line toggles so a stale bit never looks valid
   always begin
      #40;
      if (!run) begin
         din = ~din;
      end
   end

   // a new stream starts at its first bit
   always @(posedge run) begin
      rises = 0;
      din = bit_at(0);
   end

   // log the chain output and advance the address on each rise
   always @(posedge link_clk_pin) begin
      if (run) begin
         dout_log[rises] = dout;
         rises = rises + 1;
         if (master_mode) begin
            din <= #18 bit_at(rises);
         end
      end
   end

   // an upstream master changes its data on the falling edge; one line for all slaves
   always @(negedge link_clk_pin) begin
      if (run && !master_mode) begin
         din = bit_at(rises);
      end
   end
endmodule
`default_nettype wire

/* test_serial_config_port.sv */
// self-checking bench for the serial configuration port
`timescale 1ns/1ns
`default_nettype none
`include "scp_defines.svh"
module test_serial_config_port;
   localparam int N = 56;
   // ones, preamble, length 56, fill, start bit, own bits, forwarded bits, start-up ones
   localparam logic [63:0] IMG = {8'hff, `SCP_PREAMBLE, 24'h00_0038, 4'hf, 1'b0, 7'h53, 8'h69,
      8'hff};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic mode_hi = 1'b1, mode_lo = 1'b1, program_n = 1'b0, init_ext = 1'b0;
   logic run = 1'b0, master = 1'b0;
   logic hreadyout, hresp, init_out, init_oe, clk_out, clk_oe, din, dout, done, hi_cfg, lo_cfg;
   logic clk_drive, init_in, link_clk_pin;
   logic [31:0] hrdata;
   logic [31:0] junk;
   logic [127:0] dlog;
   int rises, fail_count = 0, total_checks = 0;

   // open-drain init wire and shared configuration clock wire
   assign init_in = init_oe ? init_out : init_ext;
   assign link_clk_pin = clk_oe ? clk_out : clk_drive;
   always #2 hclk = ~hclk;

   scp_serial_config_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode_select_high(mode_hi),
      .mode_select_low(mode_lo), .program_n(program_n), .init_in(init_in),
      .init_out(init_out), .init_oe(init_oe), .config_clock_in(link_clk_pin),
      .config_clock_out(clk_out), .config_clock_oe(clk_oe), .din(din), .dout(dout),
      .done(done), .high_during_config(hi_cfg), .low_during_config(lo_cfg));

   scp_prom_model prom (.master_mode(master), .run(run), .stream(IMG),
      .link_clk_pin(link_clk_pin), .dout(dout), .link_clk_drive(clk_drive), .din(din),
      .rises(rises), .dout_log(dlog));

   // ----------------------------------------------------------
   // reporting
   // ----------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // a wait that runs out counts as a mismatch and ends the run
   task automatic timed_out(input int n, input int lim);
      if (n >= lim) begin
         check("wait bound", 32'(n), 32'(lim - 1));
         end_of_test();
      end
   endtask

   // ----------------------------------------------------------
   // ahb-lite single word transfers, each phase held until ready is seen
   // ----------------------------------------------------------
   task automatic wait_ready(output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      timed_out(n, 50);
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready(n);
      rd = hrdata;
   endtask

   task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] mask,
      input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      check(what, d & mask, exp);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic wait_rises(input int k);
      int n = 0;
      while (rises < k && n < 40000) begin
         @(posedge hclk);
         n++;
      end
      timed_out(n, 40000);
   endtask

   // count hclk cycles in one high phase of the master clock, read between edges
   task automatic high_time(input int exp);
      int n = 0;
      while (clk_out !== 1'b0 && n < 1000) begin
         @(negedge hclk);
         n++;
      end
      while (clk_out !== 1'b1 && n < 1000) begin
         @(negedge hclk);
         n++;
      end
      timed_out(n, 1000);
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (clk_out === 1'b1 && n < 1000);
      check("clock high cycles", 32'(n), 32'(exp));
   endtask

   // ----------------------------------------------------------
   // configuration runs
   // ----------------------------------------------------------
   task automatic restart(input logic hi, input logic lo);
      @(posedge hclk);
      program_n <= 1'b0;
      mode_hi <= hi;
      mode_lo <= lo;
      master <= hi & ~lo;
      init_ext <= 1'b0;
      run <= 1'b0;
      cycles(10);
      program_n <= 1'b1;
      cycles(100);
      check("init pulled low", 32'({init_oe, init_in}), 32'h2);
      cycles(300);
      check("init released", 32'(init_oe), 32'h0);
      rd_chk("held while init low", `SCP_OFF_STATUS, 32'h3f, 32'h4);
      rd_chk("clock count idle", `SCP_OFF_CLOCKS, 32'h00ff_ffff, 32'h0);
      init_ext <= 1'b1;
      run <= 1'b1;
   endtask

   // chain output, length capture, start-up timing and user outputs
   task automatic stream_checks();
      wait_rises(N + 1);
      cycles(10);
      check("done early", 32'(done), 32'h0);
      wait_rises(N + 2);
      cycles(20);
      check("done", 32'(done), 32'h1);
      run <= 1'b0;
      for (int r = 0; r < N - 1; r++) begin
         check("chain output", 32'(dlog[r + 1]), 32'((r >= 40 && r <= 47) | IMG[63 - r]));
      end
      rd_chk("length", `SCP_OFF_LENGTH, 32'h00ff_ffff, 32'(N));
      check("user outputs", 32'({hi_cfg, lo_cfg}), 32'h1);
      rd_chk("finished", `SCP_OFF_STATUS, 32'h103f, 32'h1020);
   endtask

   initial begin
      cycles(1);
      @(negedge hclk);
      check("reset outputs", 32'({hreadyout, hresp, dout, done, hi_cfg, lo_cfg}), 32'h2a);
      cycles(1);
      hresetn <= 1'b1;
      cycles(300);
      rd_chk("held by program", `SCP_OFF_STATUS, 32'h3f, 32'h1);
      check("no master clock", 32'(clk_oe), 32'h0);
      rd_chk("control reset", `SCP_OFF_CTRL, 32'h7, 32'(`SCP_CTRL_RESET));
      rd_chk("frame reset", `SCP_OFF_FRAME_BITS, 32'hffff_ffff, 32'(`SCP_FRAME_BITS_RESET));
      rd_chk("unmapped", 32'h0000_0020, 32'hffff_ffff, 32'h0);
      ahb(1'b1, `SCP_OFF_FRAME_BITS, 32'h8, junk);
      rd_chk("frame bits", `SCP_OFF_FRAME_BITS, 32'hffff_ffff, 32'h8);
      restart(1'b0, 1'b0);
      cycles(200);
      rd_chk("express refused", `SCP_OFF_STATUS, 32'h400, 32'h400);
      check("express idle", 32'({done, clk_oe}), 32'h0);
      restart(1'b1, 1'b1);
      stream_checks();
      ahb(1'b1, `SCP_OFF_CTRL, 32'h3, junk);
      restart(1'b1, 1'b0);
      high_time(`SCP_SLOW_HALF);
      wait_rises(50);
      high_time(`SCP_FAST_HALF);
      stream_checks();
      end_of_test();
   end
endmodule
`default_nettype wire
